// ### dv/tb.sv
`timescale 1ns/1ps
`include "tlx_params.svh"
module tb;
  import tlx_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] instr_in = 16'h0000;
  logic [7:0] file_rdata_in = 8'h00;
  logic [7:0] file_addr_out;
  logic file_rd_out;
  logic file_wr_out;
  logic [7:0] file_wdata_out;
  logic [15:0] table_latch_out;
  logic [7:0] working_register_out;
  logic zero_flag_out;
  logic skip_out;
  phase_t phase_out;
  logic rd_q2;
  logic [7:0] ad_q2;
  logic wr_q4;
  logic [7:0] wd_q4;
  logic [15:0] lat_q4;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;

  table_latch_skip_xor_exec u_dut (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .instr_in(instr_in),
    .file_rdata_in(file_rdata_in),
    .file_addr_out(file_addr_out),
    .file_rd_out(file_rd_out),
    .file_wr_out(file_wr_out),
    .file_wdata_out(file_wdata_out),
    .table_latch_out(table_latch_out),
    .working_register_out(working_register_out),
    .zero_flag_out(zero_flag_out),
    .skip_out(skip_out),
    .phase_out(phase_out)
  );

  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 500) begin
      failures++;
      wrap_up();
    end
  end

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one instruction; second and fourth phase outputs captured
  task run(input logic [15:0] i, input logic [7:0] d);
    while (phase_out !== PH_Q1) begin
      @(posedge mclk_in);
      #1;
    end
    instr_in = i;
    file_rdata_in = d;
    @(posedge mclk_in);
    #1;
    rd_q2 = file_rd_out;
    ad_q2 = file_addr_out;
    repeat (2) @(posedge mclk_in);
    #1;
    wr_q4 = file_wr_out;
    wd_q4 = file_wdata_out;
    lat_q4 = table_latch_out;
    @(posedge mclk_in);
    #1;
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_latch;
    run(16'hA410, 8'hB7);
    chk(lat_q4, `LATCH_RESET);
    chk({7'h00, rd_q2, ad_q2}, 16'h0110);
    chk(table_latch_out, 16'h00B7);
    run(16'hA610, 8'h5A);
    chk(lat_q4, 16'h00B7);
    chk(table_latch_out, 16'h5AB7);
    run(16'hA022, 8'h00);
    chk({7'h00, rd_q2, ad_q2}, 16'h0022);
    chk({7'h00, wr_q4, wd_q4}, 16'h01B7);
    run(16'hA222, 8'h00);
    chk({7'h00, wr_q4, wd_q4}, 16'h015A);
    chk(table_latch_out, 16'h5AB7);
  endtask

  task t_skip;
    run(16'h3310, 8'h00);
    chk({7'h00, rd_q2, ad_q2}, 16'h0110);
    chk({15'h0000, skip_out}, 16'h0001);
    run(16'hA410, 8'h11);
    chk({15'h0000, rd_q2}, 16'h0000);
    chk(table_latch_out, 16'h5AB7);
    chk({15'h0000, skip_out}, 16'h0000);
    run(16'h3310, 8'h01);
    chk({15'h0000, skip_out}, 16'h0000);
  endtask

  task t_xor;
    run(16'hB4AF, 8'h00);
    chk({7'h00, zero_flag_out, working_register_out}, 16'h00AF);
    run(16'hB4AF, 8'h00);
    chk({7'h00, zero_flag_out, working_register_out}, 16'h0100);
    run(16'h3310, 8'h05);
    chk({7'h00, zero_flag_out, working_register_out}, 16'h0100);
  endtask

  // reset in mid-run clears state, first word after release runs
  task t_reset;
    rst_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    chk(table_latch_out, `LATCH_RESET);
    chk({8'h00, working_register_out}, {8'h00, `WORKING_REG_RESET});
    chk({15'h0000, zero_flag_out}, {15'h0000, `ZFLAG_RESET});
    chk({15'h0000, skip_out}, 16'h0000);
    chk({12'h000, phase_out}, {12'h000, PH_Q1});
    run(16'hB40F, 8'h00);
    chk({7'h00, zero_flag_out, working_register_out}, 16'h000F);
  endtask

  task wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    t_latch();
    t_skip();
    t_xor();
    t_reset();
    wrap_up();
  end
endmodule

bind table_latch_skip_xor_exec tlx_chk u_chk (
  .mclk_in(mclk_in),
  .rst_in(rst_in),
  .instr_in(instr_in),
  .file_rdata_in(file_rdata_in),
  .file_addr_out(file_addr_out),
  .file_rd_out(file_rd_out),
  .file_wr_out(file_wr_out),
  .file_wdata_out(file_wdata_out),
  .table_latch_out(table_latch_out),
  .working_register_out(working_register_out),
  .zero_flag_out(zero_flag_out),
  .skip_out(skip_out),
  .phase_out(phase_out)
);

// ### dv/tlx_chk.sv
`timescale 1ns/1ps
`include "tlx_params.svh"
module tlx_chk (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [15:0] instr_in,
  input wire logic [7:0] file_rdata_in,
  input wire logic [7:0] file_addr_out,
  input wire logic file_rd_out,
  input wire logic file_wr_out,
  input wire logic [7:0] file_wdata_out,
  input wire logic [15:0] table_latch_out,
  input wire logic [7:0] working_register_out,
  input wire logic zero_flag_out,
  input wire logic skip_out,
  input wire tlx_pkg::phase_t phase_out
);
  import tlx_pkg::*;
  default clocking dclk @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  // ---------------------------------------------
  // sequences
  // ---------------------------------------------
  sequence skip_run;
    skip_out[*4] ##1 !skip_out;
  endsequence
  sequence wr_pulse;
    phase_out == PH_Q4 ##1 !file_wr_out;
  endsequence

  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  ring_step_a: assert property (
    phase_out == PH_Q4 |=> phase_out == PH_Q1)
    else $error("phase order broken");
  read_q2_a: assert property (
    file_rd_out |-> phase_out == PH_Q2)
    else $error("file read outside second phase");
  rd_cause_a: assert property (
    file_rd_out |-> $past(instr_in[15:8]) == `OPC_TEST_ZERO_SKIP
    || $past(instr_in[15:10]) == `OPC_LATCH_HI)
    else $error("file read uncaused");
  skip_len_a: assert property (
    $rose(skip_out) |-> $past(file_rdata_in, 3) == 8'h00 ##0 skip_run)
    else $error("skip wrong");
  skip_quiet_a: assert property (
    skip_out |-> !file_rd_out && !file_wr_out)
    else $error("access in forced idle cycle");
  wr_q4_a: assert property (
    file_wr_out |-> wr_pulse)
    else $error("file write timing");
  latch_keep_a: assert property (
    file_wr_out |=> $stable(table_latch_out))
    else $error("latch changed by latch read");
  latch_when_a: assert property (
    $changed(table_latch_out) |-> $past(phase_out) == PH_Q4)
    else $error("latch changed off phase four");
  latch_one_a: assert property (
    $changed(table_latch_out[15:8]) |-> $stable(table_latch_out[7:0]))
    else $error("both latch bytes changed");
  zero_ok_a: assert property (
    $changed(working_register_out)
    |-> zero_flag_out == (working_register_out == 8'h00))
    else $error("zero flag");
endmodule

// ### hdl/latch_byte.sv
`timescale 1ns/1ps
`include "tlx_params.svh"
module latch_byte (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [7:0] data_in,
  output logic [7:0] value_out
);
  logic [7:0] next_value;
  always_comb begin
    next_value = value_out;
    if (load_in) begin
      next_value = data_in;
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      value_out <= `BYTE_RESET;
    end else begin
      value_out <= next_value;
    end
  end
endmodule

// ### hdl/table_latch_skip_xor_exec.sv
`timescale 1ns/1ps
`include "tlx_params.svh"
// Function
// - latch write copies file to selected byte
// - latch holds word for program write
// - zero file value skips next instruction
// - decode 0x33 upper byte, flags untouched
// - skip cycle is forced no-operation
// - xor literal into working register, zero
// - latch read copies byte to file
module table_latch_skip_xor_exec (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [15:0] instr_in,
  input wire logic [7:0] file_rdata_in,
  output logic [7:0] file_addr_out,
  output logic file_rd_out,
  output logic file_wr_out,
  output logic [7:0] file_wdata_out,
  output logic [15:0] table_latch_out,
  output logic [7:0] working_register_out,
  output logic zero_flag_out,
  output logic skip_out,
  output tlx_pkg::phase_t phase_out
);
  import tlx_pkg::*;

  // ---------------------------------------------
  // registers and strobes
  // ---------------------------------------------
  phase_t phase;
  phase_t next_phase;
  op_t op;
  op_t next_op;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic skip_cyc;
  logic next_skip_cyc;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [7:0] wdata;
  logic [7:0] next_wdata;
  logic fwr;
  logic next_fwr;
  logic [7:0] work_reg;
  logic [7:0] next_work_reg;
  logic zflag;
  logic next_zflag;
  logic [7:0] xor_res;
  logic ld_lo;
  logic ld_hi;
  logic [7:0] lat_lo;
  logic [7:0] lat_hi;

  // ---------------------------------------------
  // instruction decode
  // ---------------------------------------------
  function automatic op_t decode(input logic [15:0] i);
    if (i[15:10] == `OPC_LATCH_HI) begin
      decode = OP_LWR;
    end else if (i[15:10] == `OPC_LATCH_RD) begin
      decode = OP_LRD;
    end else if (i[15:8] == `OPC_TEST_ZERO_SKIP) begin
      decode = OP_TSZ;
    end else if (i[15:8] == `OPC_XOR_LITERAL) begin
      decode = OP_XOR;
    end else begin
      decode = OP_NONE;
    end
  endfunction

  // ---------------------------------------------
  // phase sequencer
  // ---------------------------------------------
  always_comb begin
    next_phase = PH_Q1;
    case (phase)
      PH_Q1: begin
        next_phase = PH_Q2;
      end
      PH_Q2: begin
        next_phase = PH_Q3;
      end
      PH_Q3: begin
        next_phase = PH_Q4;
      end
      PH_Q4: begin
        next_phase = PH_Q1;
      end
      default: begin
        next_phase = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // ---------------------------------------------
  // instruction register and skip cycle
  // ---------------------------------------------
  always_comb begin
    next_ir = ir;
    next_op = op;
    next_skip_cyc = skip_cyc;
    case (phase)
      PH_Q1: begin
        next_ir = instr_in;
        // forced no-operation discards the prefetched word
        next_op = skip_cyc ? OP_NONE : decode(instr_in);
      end
      PH_Q4: begin
        next_skip_cyc = 1'b0;
        if (op == OP_TSZ) begin
          next_skip_cyc = (rdata == 8'h00);
        end
      end
      default: begin
        next_skip_cyc = skip_cyc;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ir <= `IR_RESET;
      op <= OP_NONE;
      skip_cyc <= 1'b0;
    end else begin
      ir <= next_ir;
      op <= next_op;
      skip_cyc <= next_skip_cyc;
    end
  end

  // ---------------------------------------------
  // file data path
  // ---------------------------------------------
  always_comb begin
    next_rdata = rdata;
    next_wdata = wdata;
    next_fwr = 1'b0;
    case (phase)
      PH_Q2: begin
        next_rdata = file_rdata_in;
      end
      PH_Q3: begin
        // write strobe stands through the fourth phase only
        if (op == OP_LRD) begin
          next_wdata = ir[`POS_LATCH_T] ? lat_hi : lat_lo;
          next_fwr = 1'b1;
        end
      end
      default: begin
        next_fwr = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata <= `BYTE_RESET;
      wdata <= `BYTE_RESET;
      fwr <= 1'b0;
    end else begin
      rdata <= next_rdata;
      wdata <= next_wdata;
      fwr <= next_fwr;
    end
  end

  // ---------------------------------------------
  // working register and zero flag
  // ---------------------------------------------
  always_comb begin
    xor_res = work_reg ^ ir[7:0];
    next_work_reg = work_reg;
    next_zflag = zflag;
    case (phase)
      PH_Q4: begin
        if (op == OP_XOR) begin
          next_work_reg = xor_res;
          next_zflag = (xor_res == 8'h00);
        end
      end
      default: begin
        next_work_reg = work_reg;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      work_reg <= `WORKING_REG_RESET;
      zflag <= `ZFLAG_RESET;
    end else begin
      work_reg <= next_work_reg;
      zflag <= next_zflag;
    end
  end

  // ---------------------------------------------
  // table latch bytes
  // ---------------------------------------------
  always_comb begin
    ld_lo = 1'b0;
    ld_hi = 1'b0;
    // the byte not selected keeps its value
    if (phase == PH_Q4 && op == OP_LWR) begin
      ld_hi = ir[`POS_LATCH_T];
      ld_lo = !ir[`POS_LATCH_T];
    end
  end

  latch_byte u_lo (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .load_in(ld_lo),
    .data_in(rdata),
    .value_out(lat_lo)
  );
  latch_byte u_hi (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .load_in(ld_hi),
    .data_in(rdata),
    .value_out(lat_hi)
  );

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign table_latch_out = {lat_hi, lat_lo};
  assign file_addr_out = ir[7:0];
  assign file_rd_out = (phase == PH_Q2) && (op == OP_LWR || op == OP_TSZ);
  assign file_wr_out = fwr;
  assign file_wdata_out = wdata;
  assign working_register_out = work_reg;
  assign zero_flag_out = zflag;
  assign skip_out = skip_cyc;
  assign phase_out = phase;
endmodule

// ### hdl/tlx_params.svh
`ifndef TLX_PARAMS_SVH
`define TLX_PARAMS_SVH
`define OPC_LATCH_HI 6'h29
`define OPC_LATCH_RD 6'h28
`define OPC_TEST_ZERO_SKIP 8'h33
`define OPC_XOR_LITERAL 8'hB4
`define POS_LATCH_T 9
`define LATCH_RESET 16'h0000
`define WORKING_REG_RESET 8'h00
`define BYTE_RESET 8'h00
`define IR_RESET 16'h0000
`define ZFLAG_RESET 1'b0
`endif

// ### hdl/tlx_pkg.sv
package tlx_pkg;
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } phase_t;
  typedef enum logic [4:0] {
    OP_NONE = 5'b00001,
    OP_LWR = 5'b00010,
    OP_LRD = 5'b00100,
    OP_TSZ = 5'b01000,
    OP_XOR = 5'b10000
  } op_t;
endpackage
